// ===== shared/epv_pkg.sv
// Constants, types and carriers shared by the EPROM program/verify port.
// Assumes one 20 MHz clock that is also the core oscillator.
package epv_pkg;

    // Boot entry and branch selection.
    localparam logic [15:0] BOOT_VECTOR        = 16'hFFE0;
    localparam logic [7:0]  BRANCH_PROG_VERIFY = 8'hE1;

    // Configuration space and bit locations.
    localparam logic [15:0] CFG_FIRST    = 16'hFE00;
    localparam logic [15:0] CFG_LOW_LAST = 16'hFE07;
    localparam logic [15:0] CFG_LAST     = 16'hFE0F;
    localparam logic [15:0] CFG_OSC0_LOC = 16'hFE00;
    localparam logic [15:0] CFG_OSC1_LOC = 16'hFE01;
    localparam logic [15:0] CFG_WDT0_LOC = 16'hFE02;
    localparam logic [15:0] CFG_WDT1_LOC = 16'hFE03;
    localparam logic [15:0] CFG_MD0_LOC  = 16'hFE04;
    localparam logic [15:0] CFG_MD1_LOC  = 16'hFE06;
    localparam logic [15:0] CFG_MD2_LOC  = 16'hFE0F;

    // Bit positions inside the 16-bit configuration word.
    localparam int OSC0_POS = 0;
    localparam int OSC1_POS = 1;
    localparam int WDT0_POS = 2;
    localparam int WDT1_POS = 3;
    localparam int MD0_POS  = 4;
    localparam int MD1_POS  = 6;
    localparam int MD2_POS  = 15;
    localparam int NO_POS   = 16;

    // Erased values and read fill.
    localparam logic [15:0] CFG_RESET   = 16'hFFFF;
    localparam logic [15:0] WORD_ERASED = 16'hFFFF;
    localparam logic [7:0]  PAD_FILL    = 8'hFF;

    // Processor mode field encodings.
    localparam logic [2:0] MD_MICROPROCESSOR = 3'h7;
    localparam logic [2:0] MD_MICROCONTROL   = 3'h6;
    localparam logic [2:0] MD_EXTENDED       = 3'h5;
    localparam logic [2:0] MD_PROTECTED      = 3'h0;

    // Timing: instruction cycle and data sample delay.
    localparam int CLK_MHZ     = 20;
    localparam int ICY_NS      = 200;
    localparam int ICY_CLKS    = ICY_NS * CLK_MHZ / 1000;
    localparam int SAMPLE_ICY  = 3;
    localparam int SAMPLE_CLKS = SAMPLE_ICY * ICY_CLKS;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LOC    = 8'h08;
    localparam logic [7:0] REG_CFG    = 8'h0C;
    localparam logic [7:0] REG_PULSES = 8'h10;

    // Control fields.
    localparam int          CTRL_PORT_EN_POS = 0;
    localparam int          CTRL_MODE2_POS   = 1;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0003;

    typedef enum logic [2:0] {
        EPV_OFF, EPV_BOOT, EPV_LOAD, EPV_VWAIT, EPV_VSHOW, EPV_PROG, EPV_PDONE
    } epv_state_t;

    // Pad word split into its two byte ports.
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } epv_pad_t;

    // All pin levels that cross into the clock domain together.
    typedef struct packed {
        logic     mode_select;
        logic     master_clear_input;
        logic     entry_strap_low_a;
        logic     entry_strap_low_b;
        logic     entry_strap_high;
        logic     program_strobe;
        logic     address_verify_strobe;
        epv_pad_t pad;
    } epv_pins_t;

endpackage : epv_pkg

// ===== hdl/epv_port.sv
// EPROM program/verify port with an AHB-Lite window for software.
// Assumes pins are asynchronous to hclk; the programmer drives strobes.
//
// Summary of operation
// RULE_01 - Entry: select high, low straps low, high strap high, clear rises.
// RULE_02 - On entry the program counter loads FFE0h and boot begins.
// RULE_03 - Programming forces internal execution; code protect stays untouched.
// RULE_04 - Boot polls the high pad byte; E1h selects program/verify.
// RULE_05 - Programmer gives no 72 clocks while clear is mid-level.
// RULE_06 - Pins unused by programming stay high impedance.
// RULE_07 - Weak pull-ups on the high pad byte throughout programming.
// RULE_08 - Mode select high disables power-up and start-up timers.
// RULE_09 - Address/verify strobe rising edge latches the 16-bit pad address.
// RULE_10 - Address loads only right after reset; new address needs re-entry.
// RULE_11 - After an address load the port enters verify at that address.
// RULE_12 - Verify pulse drives the word; the next pulse increments location.
// RULE_13 - Program strobe in verify starts programming; only from verify/program.
// RULE_14 - Pad data sampled three instruction cycles after program strobe rises.
// RULE_15 - Programming lasts as long as the program strobe stays high.
// RULE_16 - Program strobe again with verify strobe low reprograms the location.
// RULE_17 - Verify strobe rising before program falls verifies without increment.
// RULE_18 - Verify strobe rising after program falls increments, then verifies.
// RULE_19 - Configuration bits read one erased; any write programs them zero.
// RULE_20 - Programmer writes configuration locations ascending, skipping reserved ones.
// RULE_21 - Config reads give low or high byte on low pad; high reads FFh.
// RULE_22 - Config bits live at FE00-FE04, FE06, FE0F; last is optional.
// RULE_23 - Read-back: oscillator 0-1, watchdog 2-3, mode 4, 6 and high 7.
// RULE_24 - Mode field: 111 processor, 110 controller, 101 extended, 000 protected.
`timescale 1ns/100ps
module epv_port
    import epv_pkg::*;
#(
    parameter int MEM_DEPTH = 4096
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Programming pins.
    input  wire logic        mode_select,
    input  wire logic        master_clear_input,
    input  wire logic        entry_strap_low_a,
    input  wire logic        entry_strap_low_b,
    input  wire logic        entry_strap_high,
    input  wire logic        program_strobe,
    input  wire logic        address_verify_strobe,
    input  wire epv_pad_t    pad_in,
    output epv_pad_t         pad_out,
    output logic             pad_oe_n,
    // Core-side status.
    output logic [15:0]      boot_pc,
    output logic             force_internal,
    output logic             pad_high_pullup_en,
    output logic             unused_pins_hiz,
    output logic             startup_timers_off
);

    localparam int AW = $clog2(MEM_DEPTH);

    // The array index uses the low address bits, so depth must be 2**n.
    initial begin
        if (MEM_DEPTH < 2 || MEM_DEPTH > 65536 ||
            (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin
            $error("MEM_DEPTH must be a power of two up to 65536");
        end
    end

    // Configuration bit position for a location, NO_POS when reserved.
    function automatic int cfg_pos(input logic [15:0] loc);
        case (loc)
            CFG_OSC0_LOC: cfg_pos = OSC0_POS;
            CFG_OSC1_LOC: cfg_pos = OSC1_POS;
            CFG_WDT0_LOC: cfg_pos = WDT0_POS;
            CFG_WDT1_LOC: cfg_pos = WDT1_POS;
            CFG_MD0_LOC:  cfg_pos = MD0_POS;
            CFG_MD1_LOC:  cfg_pos = MD1_POS;
            CFG_MD2_LOC:  cfg_pos = MD2_POS;
            default:      cfg_pos = NO_POS;
        endcase
    endfunction : cfg_pos

    function automatic logic in_cfg(input logic [15:0] loc);
        in_cfg = (loc >= CFG_FIRST) && (loc <= CFG_LAST);
    endfunction : in_cfg

    // Pin synchroniser: stage one feeds stage two only.
    epv_pins_t pins_in;
    epv_pins_t s1_q;
    epv_pins_t s2_q;
    epv_pins_t s3_q;
    assign pins_in = '{mode_select, master_clear_input, entry_strap_low_a,
                       entry_strap_low_b, entry_strap_high, program_strobe,
                       address_verify_strobe, pad_in};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Edges are taken between the second and third stages.
    logic master_clear_input_rise;
    logic pgm_rise;
    logic pgm_fall;
    logic av_rise;
    logic stay_on;
    logic entry_ok;
    assign master_clear_input_rise = s2_q.master_clear_input & ~s3_q.master_clear_input;
    assign pgm_rise  = s2_q.program_strobe & ~s3_q.program_strobe;
    assign pgm_fall  = ~s2_q.program_strobe & s3_q.program_strobe;
    assign av_rise   = s2_q.address_verify_strobe &
                       ~s3_q.address_verify_strobe;
    assign stay_on   = s2_q.mode_select & s2_q.master_clear_input;

    // Software control and state shared with the bus slave.
    logic [31:0] ctrl_q;
    logic [15:0] cfg_q;
    logic [15:0] pulses_q;
    epv_state_t  state_q;
    epv_state_t  state_d;
    logic [15:0] loc_q;
    logic [15:0] loc_d;

    // RULE_01 entry straps
    assign entry_ok = master_clear_input_rise & s2_q.mode_select & ~s2_q.entry_strap_low_a &
                      ~s2_q.entry_strap_low_b & s2_q.entry_strap_high &
                      ctrl_q[CTRL_PORT_EN_POS];

    // Sequencer next state; losing select or clear drops back to off.
    always_comb begin
        state_d = state_q;
        loc_d   = loc_q;
        case (state_q)
            EPV_OFF: begin
                if (entry_ok) begin
                    state_d = EPV_BOOT;
                end
            end
            EPV_BOOT: begin
                // RULE_04 branch code poll
                if (s2_q.pad.high == BRANCH_PROG_VERIFY) begin
                    state_d = EPV_LOAD;
                end
            end
            EPV_LOAD: begin
                // RULE_09 RULE_10 RULE_11 one address load
                if (av_rise) begin
                    loc_d   = s2_q.pad;
                    state_d = EPV_VWAIT;
                end
            end
            EPV_VWAIT: begin
                // RULE_12 RULE_13 verify or program
                if (pgm_rise) begin
                    state_d = EPV_PROG;
                end else if (av_rise) begin
                    state_d = EPV_VSHOW;
                end
            end
            EPV_VSHOW: begin
                // RULE_12 RULE_13 increment or program
                if (pgm_rise) begin
                    state_d = EPV_PROG;
                end else if (av_rise) begin
                    loc_d   = 16'(loc_q + 16'h0001);
                    state_d = EPV_VWAIT;
                end
            end
            EPV_PROG: begin
                // RULE_15 RULE_17 hold or early verify
                if (av_rise) begin
                    state_d = EPV_VSHOW;
                end else if (pgm_fall) begin
                    state_d = EPV_PDONE;
                end
            end
            EPV_PDONE: begin
                // RULE_16 RULE_18 reprogram or step on
                if (pgm_rise) begin
                    state_d = EPV_PROG;
                end else if (av_rise) begin
                    loc_d   = 16'(loc_q + 16'h0001);
                    state_d = EPV_VSHOW;
                end
            end
            default: state_d = EPV_OFF;
        endcase
        if (!stay_on) begin
            state_d = EPV_OFF;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= EPV_OFF;
            loc_q   <= '0;
        end else begin
            state_q <= state_d;
            loc_q   <= loc_d;
        end
    end

    // Instruction-cycle divider, restarted on each program pulse so the
    // sample point is exact rather than up to one cycle early.
    logic                prog_enter;
    logic [1:0]          icy_cnt_q;
    logic                icy_en_q;
    logic [1:0]          samp_cnt_q;
    logic                prog_we;
    assign prog_enter = (state_d == EPV_PROG) && (state_q != EPV_PROG);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            icy_cnt_q <= '0;
            icy_en_q  <= 1'b0;
        end else if (prog_enter) begin
            icy_cnt_q <= '0;
            icy_en_q  <= 1'b0;
        end else begin
            icy_en_q  <= (icy_cnt_q == 2'(ICY_CLKS - 1));
            icy_cnt_q <= (icy_cnt_q == 2'(ICY_CLKS - 1)) ? '0 :
                         2'(icy_cnt_q + 2'h1);
        end
    end

    // RULE_14 sample delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_cnt_q <= '0;
        end else if (prog_enter) begin
            samp_cnt_q <= 2'(SAMPLE_ICY);
        end else if (icy_en_q && samp_cnt_q != '0) begin
            samp_cnt_q <= 2'(samp_cnt_q - 2'h1);
        end
    end
    assign prog_we = (state_q == EPV_PROG) && icy_en_q && (samp_cnt_q == 2'h1);

    // Program memory; a per-word flag stands in for the erased state.
    logic [15:0]          mem_q [MEM_DEPTH];
    logic [MEM_DEPTH-1:0] written_q;
    logic [AW-1:0]        idx;
    logic [15:0]          mem_word;
    assign idx      = loc_q[AW-1:0];
    assign mem_word = written_q[idx] ? mem_q[idx] : WORD_ERASED;

    // EPROM cells only go from one to zero, so a write ANDs the data in.
    always_ff @(posedge hclk) begin
        if (prog_we && !in_cfg(loc_q)) begin
            mem_q[idx] <= mem_word & s2_q.pad;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            written_q <= '0;
        end else if (prog_we && !in_cfg(loc_q)) begin
            written_q[idx] <= 1'b1;
        end
    end

    // RULE_19 RULE_22 config bit programming
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= CFG_RESET;
        end else if (prog_we && cfg_pos(loc_q) != NO_POS &&
                     (loc_q != CFG_MD2_LOC || ctrl_q[CTRL_MODE2_POS])) begin
            cfg_q[cfg_pos(loc_q)] <= 1'b0;
        end
    end

    // Count of program samples, visible to software.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulses_q <= '0;
        end else if (prog_we) begin
            pulses_q <= 16'(pulses_q + 16'h0001);
        end
    end

    // RULE_21 RULE_23 read-back word
    epv_pad_t rd_word;
    always_comb begin
        rd_word = mem_word;
        if (in_cfg(loc_q)) begin
            rd_word.high = PAD_FILL;
            rd_word.low  = (loc_q <= CFG_LOW_LAST) ? cfg_q[7:0] : cfg_q[15:8];
        end
    end

    // RULE_12 pad drive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_oe_n <= 1'b1;
            pad_out  <= '0;
        end else begin
            pad_oe_n <= (state_d != EPV_VSHOW);
            if (state_d == EPV_VSHOW && state_q != EPV_VSHOW) begin
                pad_out <= '{PAD_FILL, PAD_FILL};
            end
            if (state_q == EPV_VSHOW) begin
                pad_out <= rd_word;
            end
        end
    end

    // RULE_02 RULE_03 RULE_06 RULE_07 mode outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_pc            <= '0;
            force_internal     <= 1'b0;
            pad_high_pullup_en <= 1'b0;
            unused_pins_hiz    <= 1'b0;
        end else begin
            if (entry_ok && state_q == EPV_OFF) begin
                boot_pc <= BOOT_VECTOR;
            end
            force_internal     <= (state_d != EPV_OFF);
            pad_high_pullup_en <= (state_d != EPV_OFF);
            unused_pins_hiz    <= (state_d != EPV_OFF);
        end
    end

    // RULE_08 timers off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            startup_timers_off <= 1'b0;
        end else begin
            startup_timers_off <= s2_q.mode_select;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY.
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    logic       addr_ok;
    logic [2:0] md_field;
    assign addr_ok  = hsel & hready & htrans[1];
    // RULE_24 mode field
    assign md_field = {cfg_q[MD2_POS], cfg_q[MD1_POS], cfg_q[MD0_POS]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= '0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            wr_pend_q <= addr_ok & hwrite;
            wr_addr_q <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                case (haddr[7:0])
                    REG_CTRL:   hrdata <= ctrl_q;
                    REG_STATUS: hrdata <= {24'h0, md_field,
                                           state_q == EPV_PROG,
                                           state_q != EPV_OFF,
                                           3'(state_q)};
                    REG_LOC:    hrdata <= {16'h0, loc_q};
                    REG_CFG:    hrdata <= {16'h0, cfg_q};
                    REG_PULSES: hrdata <= {16'h0, pulses_q};
                    default:    hrdata <= '0;
                endcase
            end
        end
    end

    // Only the control register is writable; its unused bits read zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_pend_q && wr_addr_q == REG_CTRL) begin
            ctrl_q <= {30'h0, hwdata[1:0]};
        end
    end

    // Cycles spent in the program state, read only by assertions.
    logic [7:0] prog_age_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prog_age_q <= '0;
        end else if (prog_enter) begin
            prog_age_q <= '0;
        end else if (state_q == EPV_PROG && prog_age_q != 8'hFF) begin
            prog_age_q <= 8'(prog_age_q + 8'h01);
        end
    end

    sequence s_early_verify;
        state_q == EPV_PROG ##0 av_rise ##0 stay_on;
    endsequence
    sequence s_late_verify;
        state_q == EPV_PDONE ##0 !pgm_rise ##0 av_rise ##0 stay_on;
    endsequence

    a_boot_vector: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
        (state_q == EPV_OFF && entry_ok) |=> (boot_pc == BOOT_VECTOR &&
        state_q == EPV_BOOT && force_internal))
        else $error("boot entry did not load the vector");
    a_branch_select: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
        (state_q == EPV_BOOT && stay_on &&
         s2_q.pad.high == BRANCH_PROG_VERIFY) |=> state_q == EPV_LOAD)
        else $error("branch code not taken");
    a_address_latch: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
        (state_q == EPV_LOAD && av_rise && stay_on) |=>
        (loc_q == $past(s2_q.pad) && state_q == EPV_VWAIT))
        else $error("address not latched into verify");
    a_verify_drive: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        (state_q == EPV_VWAIT && av_rise && !pgm_rise && stay_on) |=>
        !pad_oe_n ##1 pad_out == $past(rd_word))
        else $error("verify did not drive the word");
    a_sample_point: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_14
        prog_we |-> prog_age_q == 8'(SAMPLE_CLKS))
        else $error("data sampled at the wrong time");
    a_reprogram_same: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_16
        (state_q == EPV_PDONE && pgm_rise && stay_on) |=>
        (state_q == EPV_PROG && $stable(loc_q)))
        else $error("reprogram moved the location");
    a_early_verify: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_17
        s_early_verify |=> (state_q == EPV_VSHOW && $stable(loc_q)))
        else $error("early verify changed the location");
    a_late_verify: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
        s_late_verify |=> (loc_q == 16'($past(loc_q) + 16'h0001) &&
        state_q == EPV_VSHOW))
        else $error("late verify did not increment");
    a_cfg_program: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_19
        (prog_we && loc_q == CFG_OSC0_LOC) |=> !cfg_q[OSC0_POS])
        else $error("config bit not programmed");
    a_cfg_readback: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_21
        (!pad_oe_n && $past(state_q) == EPV_VSHOW && in_cfg($past(loc_q)))
        |-> pad_out.high == PAD_FILL)
        else $error("config read high byte not filled");
    a_pullup_mode: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
        (state_q != EPV_OFF && stay_on) |=> (pad_high_pullup_en &&
        unused_pins_hiz))
        else $error("pull-ups or high-impedance lost in programming");

endmodule : epv_port

// ===== verification/epv_prog_model.sv
// Device-programmer model: drives straps, both strobes and the pad pins.
// Assumes it shares hclk with the port and that callers wait on its tasks.
`timescale 1ns/100ps
module epv_prog_model
    import epv_pkg::*;
(
    // Clock and device pad drive.
    input  wire logic     hclk,
    input  wire epv_pad_t pad_out,
    input  wire logic     pad_oe_n,
    // Programmer pins.
    output logic          mode_select,
    output logic          master_clear_input,
    output logic          entry_strap_low_a,
    output logic          entry_strap_low_b,
    output logic          entry_strap_high,
    output logic          program_strobe,
    output logic          address_verify_strobe,
    output epv_pad_t      pad_in
);
    logic        drv = 1'b0;
    logic [15:0] val = 16'h0000;
    // Released pads: high byte pulled up, low byte never stale.
    assign pad_in = !pad_oe_n ? pad_out : drv ? val : {PAD_FILL, ~val[7:0]};
    // All pins start low so no strobe edge is seen before entry.
    initial begin
        {mode_select, master_clear_input, entry_strap_high} = 3'h0;
        {entry_strap_low_a, entry_strap_low_b} = 2'h0;
        {program_strobe, address_verify_strobe} = 2'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    task automatic enter();
        mode_select      <= 1'b1;
        entry_strap_high <= 1'b1;
        drv              <= 1'b1;
        val              <= {BRANCH_PROG_VERIFY, 8'h00};
        tick(6);
        // Clear steps high at once, never idling mid-level.
        master_clear_input <= 1'b1;
        tick(12);
    endtask : enter
    // Dropping clear is the only way to a new address.
    task automatic leave();
        master_clear_input <= 1'b0;
        tick(8);
    endtask : leave
    // Pads settle before the strobe rises.
    task automatic av(input logic [15:0] v, input logic d);
        drv <= d;
        val <= v;
        tick(3);
        address_verify_strobe <= 1'b1;
        tick(6);
        address_verify_strobe <= 1'b0;
        tick(6);
    endtask : av
    // Data first, then a long program pulse.
    task automatic prog(input logic [15:0] v);
        drv <= 1'b1;
        val <= v;
        tick(3);
        program_strobe <= 1'b1;
        tick(30);
    endtask : prog
    task automatic exit_lo();
        program_strobe <= 1'b0;
        tick(6);
    endtask : exit_lo
    // Verify strobe rises while the program strobe is still high.
    task automatic exit_av();
        drv                   <= 1'b0;
        address_verify_strobe <= 1'b1;
        tick(6);
        program_strobe <= 1'b0;
        tick(3);
        address_verify_strobe <= 1'b0;
        tick(6);
    endtask : exit_av
endmodule : epv_prog_model

// ===== verification/epv_port_tb.sv
// Self-checking bench for the EPROM program/verify port.
// Assumes the programmer model and the AHB master share one 20 MHz hclk.
`timescale 1ns/100ps
module epv_port_tb
    import epv_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic        hreadyout, hresp, pad_oe_n, force_internal;
    logic        pad_high_pullup_en, unused_pins_hiz, startup_timers_off;
    logic        mode_select, master_clear_input, entry_strap_high;
    logic        entry_strap_low_a, entry_strap_low_b;
    logic        program_strobe, address_verify_strobe;
    logic [15:0] boot_pc, a, cfg;
    epv_pad_t    pad_in, pad_out;
    int          fails = 0, comparisons = 0, seed = 18131;
    int          mem[int];
    // Free-running bus clock.
    always #25 hclk = ~hclk;
    epv_port i_epv_port (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .mode_select, .master_clear_input, .entry_strap_low_a,
        .entry_strap_low_b, .entry_strap_high, .program_strobe,
        .address_verify_strobe, .pad_in, .pad_out, .pad_oe_n, .boot_pc,
        .force_internal, .pad_high_pullup_en, .unused_pins_hiz,
        .startup_timers_off);
    epv_prog_model i_prog (.hclk, .pad_out, .pad_oe_n, .mode_select,
        .master_clear_input, .entry_strap_low_a, .entry_strap_low_b,
        .entry_strap_high, .program_strobe, .address_verify_strobe, .pad_in);
    task chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask : chk
    // One single AHB transfer; waits on hready, never on a fixed count.
    task ahb(input logic w, input logic [7:0] ad, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, ad};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= 32'($random(seed));
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    function automatic logic [15:0] word(input int x);
        return mem.exists(x) ? 16'(mem[x]) : WORD_ERASED;
    endfunction : word
    // Reference: an EPROM write can only clear bits.
    task pgm(input logic [15:0] x);
        logic [15:0] v;
        v = 16'($random(seed));
        mem[x] = word(x) & v;
        i_prog.prog(v);
    endtask : pgm
    task stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // Watchdog well beyond the expected few hundred cycles.
    initial begin
        #2000000;
        fails++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        chk("reset", 17'h1, {boot_pc, pad_oe_n});
        i_prog.enter();
        chk("entry", {BOOT_VECTOR, 4'hF}, {boot_pc, force_internal,
            pad_high_pullup_en, unused_pins_hiz, startup_timers_off});
        $display("test entry done");
        a = 16'($random(seed)) & 16'h0FFC;
        i_prog.av(a, 1'b1);
        i_prog.av(a, 1'b0);
        chk("verify", {1'b0, word(a)}, {pad_oe_n, pad_out});
        pgm(a);
        i_prog.exit_lo();
        pgm(a);
        i_prog.exit_av();
        chk("same", {1'b0, word(a)}, {pad_oe_n, pad_out});
        i_prog.av(a, 1'b0);
        chk("step", 1'b1, pad_oe_n);
        i_prog.av(a, 1'b0);
        chk("next", {1'b0, word(a + 1)}, {pad_oe_n, pad_out});
        pgm(a + 16'h1);
        i_prog.exit_lo();
        i_prog.av(a, 1'b0);
        chk("incr", {1'b0, word(a + 2)}, {pad_oe_n, pad_out});
        ahb(1'b1, REG_LOC, r);
        ahb(1'b0, REG_LOC, r);
        chk("loc", {16'h0, a + 16'h2}, r);
        chk("resp", 1'b0, hresp);
        $display("test program done");
        i_prog.leave();
        chk("left", 1'b0, force_internal);
        i_prog.enter();
        i_prog.av(CFG_FIRST, 1'b1);
        i_prog.av(CFG_FIRST, 1'b0);
        chk("cfg0", {PAD_FILL, CFG_RESET[7:0]}, pad_out);
        i_prog.prog(16'($random(seed)));
        i_prog.exit_lo();
        i_prog.av(CFG_FIRST, 1'b0);
        cfg = CFG_RESET & ~(16'h1 << OSC0_POS);
        chk("cfg1", {PAD_FILL, cfg[7:0]}, pad_out);
        ahb(1'b0, REG_CFG, r);
        chk("cfgreg", {16'h0, cfg}, r);
        ahb(1'b0, REG_STATUS, r);
        chk("mode", {MD_MICROPROCESSOR, 1'b1}, {r[7:5], r[3]});
        ahb(1'b0, REG_CTRL, r);
        chk("ctrl", CTRL_RESET, r);
        ahb(1'b0, 8'h40, r);
        chk("unmapped", 32'h0, r);
        $display("test config done");
        stop_test();
    end
endmodule : epv_port_tb
